/* rtl/pmar_pkg.sv */
package pmar_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int ALM_W = 6;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_POWER_MODE_SELECT_B = 12'h29A;
  localparam logic [ADDR_W-1:0] OFS_POWER_MODE_SELECT_C = 12'h29B;
  localparam logic [ADDR_W-1:0] OFS_POWER_MODE_SELECT_D = 12'h29C;
  localparam logic [ADDR_W-1:0] OFS_ALARM_SUMMARY = 12'h2C0;
  localparam logic [ADDR_W-1:0] OFS_ALERT_FLAG_STATUS = 12'h2C1;
  localparam logic [ADDR_W-1:0] OFS_ALERT_MASK = 12'h2C2;

  // Reset values
  localparam logic [DATA_W-1:0] RST_POWER_MODE_SELECT_B = 8'h0F;
  localparam logic [DATA_W-1:0] RST_POWER_MODE_SELECT_C = 8'h04;
  localparam logic [DATA_W-1:0] RST_POWER_MODE_SELECT_D = 8'h1B;
  localparam logic [DATA_W-1:0] RST_ALARM_SUMMARY = 8'h00;
  localparam logic [ALM_W-1:0] RST_ALERT_FLAG_STATUS = 6'h3F;
  localparam logic [ALM_W-1:0] RST_ALERT_MASK = 6'h3F;
  localparam logic [DATA_W-1:0] RST_READ_DATA = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ_DATA = 8'h00;

  // Defined codes per register
  localparam logic [DATA_W-1:0] CODE_B_LOW = 8'h06;
  localparam logic [DATA_W-1:0] CODE_B_HIGH = 8'h0F;
  localparam logic [DATA_W-1:0] CODE_C_LOW = 8'h00;
  localparam logic [DATA_W-1:0] CODE_C_HIGH = 8'h04;
  localparam logic [DATA_W-1:0] CODE_D_LOW = 8'h14;
  localparam logic [DATA_W-1:0] CODE_D_HIGH = 8'h1B;

  // Alarm field positions
  localparam int ALM_CLK_POS = 0;
  localparam int ALM_RSVD_POS = 1;
  localparam int ALM_REALIGNED_POS = 2;
  localparam int ALM_LINK_POS = 3;
  localparam int ALM_SPLL_POS = 4;
  localparam int ALM_FIFO_POS = 5;
  localparam int ALARM_SUMMARY_POS = 0;

  typedef enum logic [1:0] {
    PMAR_MODE_HIGH = 2'b00,
    PMAR_MODE_LOW = 2'b01,
    PMAR_MODE_RSVD = 2'b10
  } pmar_mode_e;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pmar_req_s;

  typedef struct packed {
    logic rd_valid;
    logic [DATA_W-1:0] rdata;
  } pmar_rsp_s;

  typedef struct packed {
    logic [DATA_W-1:0] code_b;
    logic [DATA_W-1:0] code_c;
    logic [DATA_W-1:0] code_d;
    pmar_mode_e mode;
    logic mixed;
  } pmar_power_s;

endpackage : pmar_pkg

/* rtl/pmar_alarm_merge.sv */
module pmar_alarm_merge #(
  parameter int WIDTH = 6
) (
  input wire logic [WIDTH-1:0] flags,
  input wire logic [WIDTH-1:0] mask,
  output logic summary
);

  // Purely combinational so the pin follows the flags in the same cycle
  always_comb begin
    summary = |(flags & ~mask);
  end

endmodule : pmar_alarm_merge

/* rtl/pmar_regs.sv */
// Functional notes
// - Select b: 0x06 low, 0x0F high/reset
// - Select c: 0x00 low, 0x04 high/reset
// - Select d: 0x14 low, 0x1B high/reset
// - Summary read-only, bit0 alarm, rest zero
// - Per-source mask excludes it from summary
// - Summary may drive calibration status pin
// - Flag status resets 0x3F, software clears
// - Write one clears flag; reset sets all
// - Mask resets 0x3F, all sources masked
module pmar_regs (
  input wire logic clock,
  input wire logic rst,
  input wire pmar_pkg::pmar_req_s req,
  output pmar_pkg::pmar_rsp_s rsp,
  input wire logic [pmar_pkg::ALM_W-1:0] alarm_event,
  input wire logic calibration_status_sel,
  input wire logic calibration_done,
  output logic calibration_status_pin,
  output logic alarm_summary,
  output pmar_pkg::pmar_power_s power
);

  logic [pmar_pkg::DATA_W-1:0] select_b_r;
  logic [pmar_pkg::DATA_W-1:0] select_b_nxt;
  logic [pmar_pkg::DATA_W-1:0] select_c_r;
  logic [pmar_pkg::DATA_W-1:0] select_c_nxt;
  logic [pmar_pkg::DATA_W-1:0] select_d_r;
  logic [pmar_pkg::DATA_W-1:0] select_d_nxt;
  logic [pmar_pkg::ALM_W-1:0] flag_r;
  logic [pmar_pkg::ALM_W-1:0] flag_nxt;
  logic [pmar_pkg::ALM_W-1:0] mask_r;
  logic [pmar_pkg::ALM_W-1:0] mask_nxt;
  logic [pmar_pkg::ALM_W-1:0] set_vec;
  logic [pmar_pkg::ALM_W-1:0] clr_vec;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic [pmar_pkg::DATA_W-1:0] rdata_r;
  logic [pmar_pkg::DATA_W-1:0] rdata_nxt;
  logic [pmar_pkg::DATA_W-1:0] power_b_r;
  logic [pmar_pkg::DATA_W-1:0] power_c_r;
  logic [pmar_pkg::DATA_W-1:0] power_d_r;
  pmar_pkg::pmar_mode_e mode_r;
  pmar_pkg::pmar_mode_e mode_nxt;
  logic mixed_r;
  logic mixed_nxt;
  logic summary;
  logic wr_b;
  logic wr_c;
  logic wr_d;
  logic wr_flag;
  logic wr_mask;
  logic low_b;
  logic low_c;
  logic low_d;
  logic high_b;
  logic high_c;
  logic high_d;

  // Address decode
  always_comb begin
    wr_b = req.wr_en && (req.addr == pmar_pkg::OFS_POWER_MODE_SELECT_B);
    wr_c = req.wr_en && (req.addr == pmar_pkg::OFS_POWER_MODE_SELECT_C);
    wr_d = req.wr_en && (req.addr == pmar_pkg::OFS_POWER_MODE_SELECT_D);
    wr_flag = req.wr_en && (req.addr == pmar_pkg::OFS_ALERT_FLAG_STATUS);
    wr_mask = req.wr_en && (req.addr == pmar_pkg::OFS_ALERT_MASK);
  end

  // Power-mode selects: any byte is kept; code checking belongs to software
  always_comb begin
    select_b_nxt = select_b_r;
    select_c_nxt = select_c_r;
    select_d_nxt = select_d_r;
    if (wr_b) begin
      select_b_nxt = req.wdata;
    end
    if (wr_c) begin
      select_c_nxt = req.wdata;
    end
    if (wr_d) begin
      select_d_nxt = req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      select_b_r <= pmar_pkg::RST_POWER_MODE_SELECT_B;
      select_c_r <= pmar_pkg::RST_POWER_MODE_SELECT_C;
      select_d_r <= pmar_pkg::RST_POWER_MODE_SELECT_D;
    end else begin
      select_b_r <= select_b_nxt;
      select_c_r <= select_c_nxt;
      select_d_r <= select_d_nxt;
    end
  end

  // Mode decode for the analog core; reserved codes are flagged, not fixed
  always_comb begin
    low_b = (select_b_r == pmar_pkg::CODE_B_LOW);
    high_b = (select_b_r == pmar_pkg::CODE_B_HIGH);
    low_c = (select_c_r == pmar_pkg::CODE_C_LOW);
    high_c = (select_c_r == pmar_pkg::CODE_C_HIGH);
    low_d = (select_d_r == pmar_pkg::CODE_D_LOW);
    high_d = (select_d_r == pmar_pkg::CODE_D_HIGH);
    if (low_b && low_c && low_d) begin
      mode_nxt = pmar_pkg::PMAR_MODE_LOW;
    end else if (high_b && high_c && high_d) begin
      mode_nxt = pmar_pkg::PMAR_MODE_HIGH;
    end else begin
      mode_nxt = pmar_pkg::PMAR_MODE_RSVD;
    end
    // Defined codes but not all the same mode: a software slip worth seeing
    mixed_nxt = (low_b || high_b) && (low_c || high_c) && (low_d || high_d)
      && !(low_b && low_c && low_d) && !(high_b && high_c && high_d);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_r <= pmar_pkg::PMAR_MODE_HIGH;
      mixed_r <= 1'b0;
      power_b_r <= pmar_pkg::RST_POWER_MODE_SELECT_B;
      power_c_r <= pmar_pkg::RST_POWER_MODE_SELECT_C;
      power_d_r <= pmar_pkg::RST_POWER_MODE_SELECT_D;
    end else begin
      mode_r <= mode_nxt;
      mixed_r <= mixed_nxt;
      power_b_r <= select_b_r;
      power_c_r <= select_c_r;
      power_d_r <= select_d_r;
    end
  end

  always_comb begin
    power.code_b = power_b_r;
    power.code_c = power_c_r;
    power.code_d = power_d_r;
    power.mode = mode_r;
    power.mixed = mixed_r;
  end

  // Alarm flags: sticky, write-one-to-clear, a new event beats a clear
  always_comb begin
    set_vec = alarm_event;
    set_vec[pmar_pkg::ALM_RSVD_POS] = 1'b0;
    clr_vec = '0;
    if (wr_flag) begin
      clr_vec = req.wdata[pmar_pkg::ALM_W-1:0];
    end
    flag_nxt = (flag_r & ~clr_vec) | set_vec;
    mask_nxt = mask_r;
    if (wr_mask) begin
      mask_nxt = req.wdata[pmar_pkg::ALM_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flag_r <= pmar_pkg::RST_ALERT_FLAG_STATUS;
      mask_r <= pmar_pkg::RST_ALERT_MASK;
    end else begin
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
    end
  end

  pmar_alarm_merge #(
    .WIDTH(pmar_pkg::ALM_W)
  ) u_merge (
    .flags(flag_r),
    .mask(mask_r),
    .summary(summary)
  );

  always_comb begin
    alarm_summary = summary;
    // Pin is combinational so an alarm is not delayed behind the read path
    calibration_status_pin = calibration_status_sel ? summary : calibration_done;
  end

  // Read path: one cycle latency, unmapped reads return zero
  always_comb begin
    rd_valid_nxt = req.rd_en;
    rdata_nxt = rdata_r;
    if (req.rd_en) begin
      case (req.addr)
        pmar_pkg::OFS_POWER_MODE_SELECT_B: begin
          rdata_nxt = select_b_r;
        end
        pmar_pkg::OFS_POWER_MODE_SELECT_C: begin
          rdata_nxt = select_c_r;
        end
        pmar_pkg::OFS_POWER_MODE_SELECT_D: begin
          rdata_nxt = select_d_r;
        end
        pmar_pkg::OFS_ALARM_SUMMARY: begin
          rdata_nxt = pmar_pkg::RST_ALARM_SUMMARY;
          rdata_nxt[pmar_pkg::ALARM_SUMMARY_POS] = summary;
        end
        pmar_pkg::OFS_ALERT_FLAG_STATUS: begin
          rdata_nxt = {2'h0, flag_r};
        end
        pmar_pkg::OFS_ALERT_MASK: begin
          rdata_nxt = {2'h0, mask_r};
        end
        default: begin
          rdata_nxt = pmar_pkg::UNMAPPED_READ_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_valid_r <= 1'b0;
      rdata_r <= pmar_pkg::RST_READ_DATA;
    end else begin
      rd_valid_r <= rd_valid_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_comb begin
    rsp.rd_valid = rd_valid_r;
    rsp.rdata = rdata_r;
  end

endmodule : pmar_regs

/* tb/pmar_regs_asserts.sv */
module pmar_regs_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire pmar_pkg::pmar_req_s req,
  input wire pmar_pkg::pmar_rsp_s rsp,
  input wire logic [pmar_pkg::ALM_W-1:0] alarm_event,
  input wire logic calibration_status_sel,
  input wire logic calibration_done,
  input wire logic calibration_status_pin,
  input wire logic alarm_summary,
  input wire pmar_pkg::pmar_power_s power
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  logic wr_b, wr_c, wr_d;
  assign wr_b = req.wr_en && req.addr == 12'h29A;
  assign wr_c = req.wr_en && req.addr == 12'h29B;
  assign wr_d = req.wr_en && req.addr == 12'h29C;
  pin_route_a: assert property (calibration_status_pin == (calibration_status_sel ? alarm_summary : calibration_done))
    else $error("status pin route wrong");
  code_b_a: assert property (wr_b |-> ##2 power.code_b == $past(req.wdata, 2))
    else $error("select b not stored");
  code_c_a: assert property (wr_c |-> ##2 power.code_c == $past(req.wdata, 2))
    else $error("select c not stored");
  code_d_a: assert property (wr_d |-> ##2 power.code_d == $past(req.wdata, 2))
    else $error("select d not stored");
  summary_read_a: assert property (req.rd_en && req.addr == 12'h2C0 |=> rsp.rd_valid && rsp.rdata == {7'h00, $past(alarm_summary)})
    else $error("summary read wrong");
  summary_wr_a: assert property (req.wr_en && req.addr == 12'h2C0 && alarm_event == '0 |=> $stable(alarm_summary))
    else $error("summary took a write");
  mask_reset_a: assert property ($fell(rst) |-> !alarm_summary)
    else $error("summary set after reset");
  flag_clear_a: assert property (req.wr_en && req.addr == 12'h2C1 && req.wdata[5:0] == 6'h3F && alarm_event == '0 |=> !alarm_summary)
    else $error("flags not cleared");
  summary_hold_a: assert property (!$past(rst) && $past(alarm_event) == '0 && !$past(req.wr_en) |-> $stable(alarm_summary))
    else $error("summary moved without cause");
  cover property (alarm_summary && calibration_status_sel);
  cover property (rsp.rd_valid);
  cover property (wr_b);
endmodule : pmar_regs_asserts

/* tb/pmar_host.sv */
module pmar_host (
  input wire logic clock,
  output pmar_pkg::pmar_req_s req,
  input wire pmar_pkg::pmar_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // Released bus shows inverted leftovers, so stale values never look valid
  task automatic idle();
    @(negedge clock);
    req <= '{1'b0, 1'b0, ~req.addr, ~req.wdata};
  endtask : idle
  // Callers end each select run in one mode with defined codes, save the lone 0x06 and reserved 0xA5 in power_codes; idle() drops enables after
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clock);
    req <= '{1'b1, 1'b0, a, d};
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [8:0] q);
    @(negedge clock);
    req <= '{1'b0, 1'b1, a, ~req.wdata};
    @(negedge clock);
    q = rsp;
    req <= '{1'b0, 1'b0, ~a, ~req.wdata};
  endtask : rd
endmodule : pmar_host

/* tb/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [5:0] alarm_event = '0;
  logic sel = 1'b0;
  logic done = 1'b0;
  logic pin, summ;
  pmar_pkg::pmar_req_s req;
  pmar_pkg::pmar_rsp_s rsp;
  pmar_pkg::pmar_power_s power;
  int miscompares = 0;
  int cmp_count = 0;
  always #12.5 clock = ~clock;
  pmar_host host (.clock(clock), .req(req), .rsp(rsp));
  pmar_regs dut (.clock(clock), .rst(rst), .req(req), .rsp(rsp), .alarm_event(alarm_event),
    .calibration_status_sel(sel), .calibration_done(done), .calibration_status_pin(pin),
    .alarm_summary(summ), .power(power));
  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
    logic [8:0] q;
    host.rd(a, q);
    chk(q, {1'b1, e});
  endtask : chk_rd
  task automatic reset_values();
    chk_rd(12'h29A, 8'h0F);
    chk_rd(12'h29B, 8'h04);
    chk_rd(12'h29C, 8'h1B);
    chk_rd(12'h2C0, 8'h00);
    chk_rd(12'h2C1, 8'h3F);
    chk_rd(12'h2C2, 8'h3F);
    chk_rd(12'h3FF, 8'h00);
    chk({power.code_b, power.code_c, power.code_d}, 24'h0F041B);
    chk({power.mode, power.mixed}, {pmar_pkg::PMAR_MODE_HIGH, 1'b0});
  endtask : reset_values
  task automatic power_codes();
    logic [23:0] m [2] = '{24'h060014, 24'h0F041B};
    foreach (m[i]) begin
      host.wr(12'h29A, m[i][23:16]);
      host.wr(12'h29B, m[i][15:8]);
      host.wr(12'h29C, m[i][7:0]);
      host.idle();
      @(negedge clock);
      chk({power.code_b, power.code_c, power.code_d}, m[i]);
      chk({power.mode, power.mixed}, {(i == 0) ? pmar_pkg::PMAR_MODE_LOW : pmar_pkg::PMAR_MODE_HIGH, 1'b0});
      chk_rd(12'h29A, m[i][23:16]);
      chk_rd(12'h29B, m[i][15:8]);
      chk_rd(12'h29C, m[i][7:0]);
    end
    // Lone low code on purpose: the decode must flag the split
    host.wr(12'h29A, 8'h06);
    host.idle();
    @(negedge clock);
    chk({power.mode, power.mixed}, {pmar_pkg::PMAR_MODE_RSVD, 1'b1});
    // Reserved byte on purpose: the block must not filter it
    host.wr(12'h29A, 8'hA5);
    host.idle();
    chk_rd(12'h29A, 8'hA5);
    chk({power.mode, power.mixed}, {pmar_pkg::PMAR_MODE_RSVD, 1'b0});
    host.wr(12'h29A, 8'h0F);
    host.idle();
    @(negedge clock);
    chk({power.mode, power.mixed}, {pmar_pkg::PMAR_MODE_HIGH, 1'b0});
  endtask : power_codes
  task automatic alarms();
    sel = 1'b1;
    host.wr(12'h2C2, 8'h00);
    host.idle();
    chk(summ, 1'b1);
    chk(pin, 1'b1);
    host.wr(12'h2C0, 8'h00);
    host.idle();
    chk_rd(12'h2C0, 8'h01);
    host.wr(12'h2C1, 8'hFF);
    host.idle();
    chk(summ, 1'b0);
    chk_rd(12'h2C1, 8'h00);
    alarm_event = 6'h02;
    @(negedge clock);
    alarm_event = 6'h08;
    @(negedge clock);
    alarm_event = '0;
    chk(summ, 1'b1);
    chk_rd(12'h2C1, 8'h08);
    sel = 1'b0;
    #1 chk(pin, 1'b0);
    host.wr(12'h2C2, 8'h08);
    host.idle();
    chk(summ, 1'b0);
    chk_rd(12'h2C2, 8'h08);
    // Event and clear in one cycle: the event must survive
    alarm_event = 6'h21;
    host.wr(12'h2C1, 8'hFF);
    host.idle();
    alarm_event = '0;
    chk_rd(12'h2C1, 8'h21);
    done = 1'b1;
    #1 chk(pin, 1'b1);
  endtask : alarms
  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    reset_values();
    power_codes();
    alarms();
    @(negedge clock);
    rst = 1'b1;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    reset_values();
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    summarize();
  end
endmodule : testbench
bind pmar_regs pmar_regs_asserts chk_u (.clock(clock), .rst(rst), .req(req), .rsp(rsp),
  .alarm_event(alarm_event), .calibration_status_sel(calibration_status_sel),
  .calibration_done(calibration_done), .calibration_status_pin(calibration_status_pin),
  .alarm_summary(alarm_summary), .power(power));
